// file: src/owl_host_end.sv
`timescale 1ns/1ps
`include "owl_defines.svh"

module owl_host_end #(
  parameter int unsigned SETTLE_CYC = `OWL_SETTLE_CYC,
  parameter int unsigned START_CYC  = `OWL_START_TYP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  owl_if.host              bus,
  input  wire logic        rd_req,
  output logic             ready,
  output logic             done,
  output logic             err,
  output logic [15:0]      hum_tenths,
  output logic             temp_neg,
  output logic [14:0]      temp_mag
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  owl_pkg::owl_host_state_e st_q;
  owl_pkg::owl_host_state_e st_d;
  logic [31:0]              cnt_q;
  logic [31:0]              cnt_d;
  logic [39:0]              sh_q;
  logic [39:0]              sh_d;
  logic [5:0]               bits_q;
  logic [5:0]               bits_d;
  logic [31:0]              data_q;
  logic [31:0]              data_d;
  logic                     done_q;
  logic                     done_d;
  logic                     err_q;
  logic                     err_d;
  logic                     oe_q;
  logic                     to;

  // ----------------------------------------
  // edge deadlines, max plus sampling slack
  // ----------------------------------------
  function automatic logic [31:0] lim(input owl_pkg::owl_host_state_e s);
    logic [31:0] r;
    r = 32'hFFFF_FFFF;
    unique case (s)
      owl_pkg::H_GO:   r = 32'(`OWL_GO_MAX_CYC);
      owl_pkg::H_RSPL,
      owl_pkg::H_RSPH: r = 32'(`OWL_RESP_MAX_CYC);
      owl_pkg::H_BITL: r = 32'(`OWL_LOW_MAX_CYC);
      owl_pkg::H_BITH: r = 32'(`OWL_H1_MAX_CYC);
      owl_pkg::H_END:  r = 32'(`OWL_EN_MAX_CYC);
      owl_pkg::H_PWR,
      owl_pkg::H_IDLE,
      owl_pkg::H_START: r = 32'hFFFF_FFFF;
    endcase
    return r;
  endfunction : lim

  assign to = (cnt_q > lim(st_q) + 32'(`OWL_EDGE_SLACK_CYC));     // RL18

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q + 32'h0000_0001;
    sh_d   = sh_q;
    bits_d = bits_q;
    data_d = data_q;
    done_d = 1'b0;
    err_d  = 1'b0;
    unique case (st_q)
      owl_pkg::H_PWR: begin
        if (cnt_q == SETTLE_CYC - 32'h0000_0001) begin
          st_d  = owl_pkg::H_IDLE;                                // RL9
          cnt_d = 32'h0000_0000;
        end
      end
      owl_pkg::H_IDLE: begin
        cnt_d = 32'h0000_0000;
        if (rd_req) begin
          st_d = owl_pkg::H_START;
        end
      end
      owl_pkg::H_START: begin
        if (cnt_q == START_CYC - 32'h0000_0001) begin
          st_d  = owl_pkg::H_GO;                                  // RL1
          cnt_d = 32'h0000_0000;
        end
      end
      owl_pkg::H_GO,
      owl_pkg::H_RSPH,
      owl_pkg::H_BITH: begin
        if (!bus.line) begin
          cnt_d = 32'h0000_0000;
          if (st_q == owl_pkg::H_BITH) begin
            // a high longer than the split point is a one
            sh_d   = {sh_q[38:0], cnt_q >= 32'(`OWL_BIT_SPLIT_CYC)}; // RL13
            bits_d = bits_q + 6'h01;
            st_d   = (bits_q == 6'(`OWL_LAST_BIT)) ? owl_pkg::H_END
                                                   : owl_pkg::H_BITL;
          end else begin
            st_d   = (st_q == owl_pkg::H_GO) ? owl_pkg::H_RSPL     // RL2
                                             : owl_pkg::H_BITL;
            bits_d = 6'h00;
          end
        end else if (to) begin
          st_d  = owl_pkg::H_IDLE;                                // RL18
          err_d = 1'b1;
        end
      end
      owl_pkg::H_RSPL,
      owl_pkg::H_BITL,
      owl_pkg::H_END: begin
        if (bus.line) begin
          cnt_d = 32'h0000_0000;
          if (st_q == owl_pkg::H_END) begin
            st_d = owl_pkg::H_IDLE;
            // a bad frame is dropped, old data kept
            if (owl_pkg::owl_check(sh_q[39:8]) == sh_q[7:0]) begin
              data_d = sh_q[39:8];                                // RL17
              done_d = 1'b1;
            end else begin
              err_d = 1'b1;                                       // RL17
            end
          end else begin
            st_d = (st_q == owl_pkg::H_RSPL) ? owl_pkg::H_RSPH
                                             : owl_pkg::H_BITH;
          end
        end else if (to) begin
          st_d  = owl_pkg::H_IDLE;                                // RL18
          err_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q   <= owl_pkg::H_PWR;                                   // RL9
      cnt_q  <= 32'h0000_0000;
      sh_q   <= 40'h00_0000_0000;
      bits_q <= 6'h00;
      data_q <= 32'h0000_0000;
      done_q <= 1'b0;
      err_q  <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      bits_q <= bits_d;
      data_q <= data_d;
      done_q <= done_d;
      err_q  <= err_d;
      // drive only for the start pulse, then listen
      oe_q   <= (st_d == owl_pkg::H_START);                       // RL13
    end
  end

  assign bus.host_out = 1'b0;
  assign bus.host_oe  = oe_q;
  assign ready        = (st_q == owl_pkg::H_IDLE);
  assign done         = done_q;
  assign err          = err_q;
  assign hum_tenths   = data_q[31:16];
  assign temp_neg     = data_q[`OWL_TEMP_SIGN];
  assign temp_mag     = data_q[14:0];

endmodule : owl_host_end

// file: src/owl_defines.svh
`ifndef OWL_DEFINES_SVH
`define OWL_DEFINES_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define OWL_CLK_MHZ 10

// ----------------------------------------
// line timing, microseconds as printed; power-up settle in seconds
// ----------------------------------------
`define OWL_START_MIN_US 800
`define OWL_START_TYP_US 1000
`define OWL_START_MAX_US 20000
`define OWL_GO_MIN_US    20
`define OWL_GO_TYP_US    30
`define OWL_GO_MAX_US    200
`define OWL_RESP_MIN_US  75
`define OWL_RESP_TYP_US  80
`define OWL_RESP_MAX_US  85
`define OWL_LOW_MIN_US   48
`define OWL_LOW_TYP_US   50
`define OWL_LOW_MAX_US   55
`define OWL_H0_MIN_US    22
`define OWL_H0_TYP_US    26
`define OWL_H0_MAX_US    30
`define OWL_H1_MIN_US    68
`define OWL_H1_TYP_US    70
`define OWL_H1_MAX_US    75
`define OWL_EN_MIN_US    45
`define OWL_EN_TYP_US    50
`define OWL_EN_MAX_US    55
`define OWL_SETTLE_S     2

// ----------------------------------------
// cycle counts at the system clock
// ----------------------------------------
`define OWL_START_MIN_CYC (`OWL_START_MIN_US * `OWL_CLK_MHZ)
`define OWL_START_TYP_CYC (`OWL_START_TYP_US * `OWL_CLK_MHZ)
`define OWL_GO_TYP_CYC    (`OWL_GO_TYP_US * `OWL_CLK_MHZ)
`define OWL_GO_MAX_CYC    (`OWL_GO_MAX_US * `OWL_CLK_MHZ)
`define OWL_RESP_TYP_CYC  (`OWL_RESP_TYP_US * `OWL_CLK_MHZ)
`define OWL_RESP_MAX_CYC  (`OWL_RESP_MAX_US * `OWL_CLK_MHZ)
`define OWL_LOW_TYP_CYC   (`OWL_LOW_TYP_US * `OWL_CLK_MHZ)
`define OWL_LOW_MAX_CYC   (`OWL_LOW_MAX_US * `OWL_CLK_MHZ)
`define OWL_H0_TYP_CYC    (`OWL_H0_TYP_US * `OWL_CLK_MHZ)
`define OWL_H0_MAX_CYC    (`OWL_H0_MAX_US * `OWL_CLK_MHZ)
`define OWL_H1_MIN_CYC    (`OWL_H1_MIN_US * `OWL_CLK_MHZ)
`define OWL_H1_TYP_CYC    (`OWL_H1_TYP_US * `OWL_CLK_MHZ)
`define OWL_H1_MAX_CYC    (`OWL_H1_MAX_US * `OWL_CLK_MHZ)
`define OWL_EN_TYP_CYC    (`OWL_EN_TYP_US * `OWL_CLK_MHZ)
`define OWL_EN_MAX_CYC    (`OWL_EN_MAX_US * `OWL_CLK_MHZ)
`define OWL_SETTLE_CYC    (`OWL_SETTLE_S * 1000000 * `OWL_CLK_MHZ)
`define OWL_EDGE_SLACK_CYC 2
`define OWL_BIT_SPLIT_CYC ((`OWL_H0_MAX_CYC + `OWL_H1_MIN_CYC) / 2)

// ----------------------------------------
// frame layout
// ----------------------------------------
`define OWL_FRAME_BITS 40
`define OWL_LAST_BIT   39
`define OWL_TEMP_SIGN  15

`endif

// file: src/owl_pkg.sv
package owl_pkg;

  typedef enum logic [2:0] {
    S_MEAS, S_SLEEP, S_GO, S_RSPL, S_RSPH, S_BITL, S_BITH, S_END
  } owl_dev_state_e;

  typedef enum logic [3:0] {
    H_PWR, H_IDLE, H_START, H_GO, H_RSPL, H_RSPH, H_BITL, H_BITH, H_END
  } owl_host_state_e;

  // check byte: low eight bits of the four-byte sum
  function automatic logic [7:0] owl_check(input logic [31:0] d);
    return 8'(d[31:24] + d[23:16] + d[15:8] + d[7:0]);
  endfunction : owl_check

endpackage : owl_pkg

// file: src/owl_if.sv
`timescale 1ns/1ps

interface owl_if;
  logic line;
  logic dev_out;
  logic dev_oe;
  logic host_out;
  logic host_oe;

  // open drain with pull-up: high unless a driver pulls it low
  assign line = ~((dev_oe & ~dev_out) | (host_oe & ~host_out));

  modport dev (input line, output dev_out, output dev_oe);
  modport host (input line, output host_out, output host_oe);
endinterface : owl_if

// file: src/owl_sensor_end.sv
// What the sensor and host ends do
// RL1: host start pulse low 0.8 to 20 ms
// RL2: line high 20-200 us before response
// RL3: response low phase 75 to 85 us
// RL4: response high phase 75 to 85 us
// RL5: each bit starts low 48-55 us
// RL6: zero bit high 22 to 30 us
// RL7: one bit high 68 to 75 us
// RL8: final low 45-55 us, then release
// RL9: host waits 2 s after power-up
// RL10: measure at power-up, store, sleep, watch line
// RL11: exactly 40 bits back to back
// RL12: remeasure after transfer, sleep until start
// RL13: host releases line, times each bit
// RL14: MSB first, humidity then temperature then check
// RL15: values sent as ten times reading
// RL16: temperature sign-magnitude, bit 15 negative
// RL17: check byte is four-byte sum
// RL18: host aborts on missing edge timeout
`timescale 1ns/1ps
`include "owl_defines.svh"

module owl_sensor_end #(
  parameter int unsigned START_MIN_CYC = `OWL_START_MIN_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  owl_if.dev               bus,
  output logic             meas_req,
  input  wire logic        meas_valid,
  input  wire logic [15:0] hum_tenths,
  input  wire logic        temp_neg,
  input  wire logic [14:0] temp_mag,
  output logic             awake
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  owl_pkg::owl_dev_state_e st_q;
  owl_pkg::owl_dev_state_e st_d;
  logic [15:0]             cnt_q;
  logic [15:0]             cnt_d;
  logic [39:0]             sh_q;
  logic [39:0]             sh_d;
  logic [5:0]              bits_q;
  logic [5:0]              bits_d;
  logic                    oe_q;
  logic                    oe_d;
  logic                    tick;
  logic [31:0]             meas_word;

  // ----------------------------------------
  // phase lengths
  // ----------------------------------------
  // typical figures sit well inside every min/max window
  function automatic logic [15:0] dur(input owl_pkg::owl_dev_state_e s,
                                      input logic one);
    logic [15:0] r;
    r = 16'h0001;
    unique case (s)
      owl_pkg::S_GO:   r = 16'(`OWL_GO_TYP_CYC);                 // RL2
      owl_pkg::S_RSPL: r = 16'(`OWL_RESP_TYP_CYC);               // RL3
      owl_pkg::S_RSPH: r = 16'(`OWL_RESP_TYP_CYC);               // RL4
      owl_pkg::S_BITL: r = 16'(`OWL_LOW_TYP_CYC);                // RL5
      owl_pkg::S_BITH: begin
        if (one) begin
          r = 16'(`OWL_H1_TYP_CYC);                             // RL7
        end else begin
          r = 16'(`OWL_H0_TYP_CYC);                             // RL6
        end
      end
      owl_pkg::S_END:  r = 16'(`OWL_EN_TYP_CYC);                 // RL8
      owl_pkg::S_MEAS,
      owl_pkg::S_SLEEP: r = 16'h0001;
    endcase
    return r;
  endfunction : dur

  // ----------------------------------------
  // frame assembly
  // ----------------------------------------
  // caller supplies tenths of a unit; temperature is sign and magnitude
  assign meas_word = {hum_tenths, temp_neg, temp_mag};        // RL15 RL16

  assign tick = (cnt_q == dur(st_q, sh_q[39]) - 16'h0001);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q + 16'h0001;
    sh_d   = sh_q;
    bits_d = bits_q;
    unique case (st_q)
      owl_pkg::S_MEAS: begin
        cnt_d = 16'h0000;
        if (meas_valid) begin
          // humidity, temperature, check: sent from bit 39 down
          sh_d = {meas_word, owl_pkg::owl_check(meas_word)};      // RL14 RL17
          st_d = owl_pkg::S_SLEEP;                                // RL10
        end
      end
      owl_pkg::S_SLEEP: begin
        if (bus.line) begin
          cnt_d = 16'h0000;
          // a low shorter than the least start is a glitch
          if (cnt_q >= 16'(START_MIN_CYC)) begin
            st_d = owl_pkg::S_GO;                                 // RL1
          end
        end else if (cnt_q == 16'hFFFF) begin
          cnt_d = cnt_q;
        end
      end
      owl_pkg::S_GO: begin
        if (!bus.line) begin
          // host pulled low again: treat as a fresh start pulse
          st_d  = owl_pkg::S_SLEEP;
          cnt_d = 16'h0001;
        end else if (tick) begin
          st_d  = owl_pkg::S_RSPL;                                // RL2
          cnt_d = 16'h0000;
        end
      end
      owl_pkg::S_RSPL: begin
        if (tick) begin
          st_d  = owl_pkg::S_RSPH;                                // RL3
          cnt_d = 16'h0000;
        end
      end
      owl_pkg::S_RSPH: begin
        if (tick) begin
          st_d   = owl_pkg::S_BITL;                               // RL4
          cnt_d  = 16'h0000;
          bits_d = 6'h00;
        end
      end
      owl_pkg::S_BITL: begin
        if (tick) begin
          st_d  = owl_pkg::S_BITH;                                // RL5
          cnt_d = 16'h0000;
        end
      end
      owl_pkg::S_BITH: begin
        if (tick) begin
          cnt_d  = 16'h0000;
          sh_d   = {sh_q[38:0], 1'b0};                           // RL14
          bits_d = bits_q + 6'h01;
          if (bits_q == 6'(`OWL_LAST_BIT)) begin
            st_d = owl_pkg::S_END;                                // RL11
          end else begin
            st_d = owl_pkg::S_BITL;                               // RL11
          end
        end
      end
      owl_pkg::S_END: begin
        if (tick) begin
          // release, then take the reading served by the next read
          st_d  = owl_pkg::S_MEAS;                                // RL8 RL12
          cnt_d = 16'h0000;
        end
      end
    endcase
  end

  // ----------------------------------------
  // line drive
  // ----------------------------------------
  // registered so the pin never glitches between phases
  always_comb begin
    oe_d = (st_d == owl_pkg::S_RSPL) ||                           // RL3
           (st_d == owl_pkg::S_BITL) ||                           // RL5
           (st_d == owl_pkg::S_END);                              // RL8
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      // power-up starts with a measurement
      st_q   <= owl_pkg::S_MEAS;                                  // RL10
      cnt_q  <= 16'h0000;
      sh_q   <= 40'h00_0000_0000;
      bits_q <= 6'h00;
      oe_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      bits_q <= bits_d;
      oe_q   <= oe_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign bus.dev_out = 1'b0;
  // while asleep the pin only listens
  assign bus.dev_oe  = oe_q;                                      // RL10
  assign meas_req    = (st_q == owl_pkg::S_MEAS);                 // RL10 RL12
  assign awake       = (st_q != owl_pkg::S_MEAS) &&
                       (st_q != owl_pkg::S_SLEEP);

endmodule : owl_sensor_end

// file: verification/owl_link_monitor.sv
`timescale 1ns/1ps

module owl_link_monitor (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic line,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic host_out,
  input wire logic host_oe
);
  // ----------------------------------------
  // phase length and edge count helpers
  // ----------------------------------------
  int unsigned run_q, run_d;
  int unsigned nfall_q, nfall_d;
  // cycles since the host let go, until the response starts; a counter keeps
  // the 2000-cycle window out of a delay range
  int unsigned go_q, go_d;
  logic        oe_q, hoe_q, armed_q, armed_d;

  always_comb begin
    run_d   = (dev_oe != oe_q) ? 1 : run_q + 1;
    nfall_d = host_oe ? 0 : ((oe_q && !dev_oe) ? nfall_q + 1 : nfall_q);
    go_d    = (hoe_q && !host_oe) ? 1 : ((go_q != 0 && !dev_oe) ? go_q + 1 : 0);
    armed_d = armed_q;
    if (hoe_q && !host_oe) begin
      armed_d = 1'b1;
    end else if (oe_q && !dev_oe && nfall_q == 41) begin
      armed_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_q   <= 0;
      nfall_q <= 0;
      go_q    <= 0;
      oe_q    <= 1'b0;
      hoe_q   <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      run_q   <= run_d;
      nfall_q <= nfall_d;
      go_q    <= go_d;
      oe_q    <= dev_oe;
      hoe_q   <= host_oe;
      armed_q <= armed_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // line timing
  // ----------------------------------------
  AST_GO_WAIT: assert property (
    $rose(dev_oe) && go_q != 0 |-> go_q inside {[200:2000]})
    else $error("response start out of window");
  AST_GO_LATE: assert property (
    go_q <= 2000) else $error("no response within the release window");
  AST_RESP_LOW: assert property (
    $fell(dev_oe) && nfall_q == 0 |-> run_q inside {[750:850]}) else $error("response low length");
  AST_RESP_HIGH: assert property (
    $rose(dev_oe) && nfall_q == 1 |-> run_q inside {[750:850]}) else $error("response high length");
  AST_BIT_LOW: assert property (
    $fell(dev_oe) && nfall_q inside {[1:40]} |-> run_q inside {[480:550]})
    else $error("bit low length");
  AST_BIT_HIGH: assert property (
    $rose(dev_oe) && nfall_q inside {[2:41]} |-> run_q inside {[220:300], [680:750]})
    else $error("bit high length");
  AST_END_LOW: assert property (
    $fell(dev_oe) && nfall_q == 41 |-> run_q inside {[450:550]} ##1 !dev_oe [*8])
    else $error("final low or release wrong");
  AST_BIT_COUNT: assert property (
    $fell(dev_oe) |-> nfall_q <= 41) else $error("too many bits in frame");
  AST_QUIET: assert property (
    !armed_q |-> !dev_oe) else $error("sensor drives line unprompted");
  AST_DRAIN_ONLY: assert property (
    (dev_oe |-> !dev_out && !line) and (host_oe |-> !host_out && !line))
    else $error("open drain level wrong");
endmodule : owl_link_monitor

// file: verification/test_one_wire_sensor_readout_link.sv
`timescale 1ns/1ps

module test_one_wire_sensor_readout_link;
  logic        sys_clk    = 1'b0;
  logic        nrst       = 1'b0;
  logic        meas_valid = 1'b0;
  logic        temp_neg   = 1'b0;
  logic [15:0] hum_tenths = 16'h0000;
  logic [14:0] temp_mag   = 15'h0000;
  logic        rd_req     = 1'b0;
  logic        rd_req_b   = 1'b0;
  logic        meas_req, awake, ready, done, err, ready_b, done_b, err_b, neg_out;
  logic [15:0] hum_out;
  logic [14:0] mag_out;
  logic [31:0] rnd        = 32'h7C27;
  logic [31:0] exp_q[$];
  logic [39:0] wexp_q[$];
  logic [39:0] sh;
  logic        line_d     = 1'b1;
  int          run        = 0;
  int          lowlen     = 0;
  int          nb         = 40;
  int          nmeas      = 0;
  int          miscompares = 0;
  int          checks     = 0;

  always #50 sys_clk = ~sys_clk;

  // ----------------------------------------
  // design ends; lone host faces a silent line
  // ----------------------------------------
  owl_if link_if();
  owl_if lone_if();
  assign lone_if.dev_out = 1'b0;
  assign lone_if.dev_oe  = 1'b0;

  owl_sensor_end #(.START_MIN_CYC(40)) owl_sensor_end_inst (
    .sys_clk(sys_clk), .nrst(nrst), .bus(link_if), .meas_req(meas_req),
    .meas_valid(meas_valid), .hum_tenths(hum_tenths), .temp_neg(temp_neg),
    .temp_mag(temp_mag), .awake(awake));
  owl_host_end #(.SETTLE_CYC(50), .START_CYC(60)) owl_host_end_inst (
    .sys_clk(sys_clk), .nrst(nrst), .bus(link_if), .rd_req(rd_req), .ready(ready),
    .done(done), .err(err), .hum_tenths(hum_out), .temp_neg(neg_out), .temp_mag(mag_out));
  owl_host_end #(.SETTLE_CYC(50), .START_CYC(60)) owl_host_end_inst2 (
    .sys_clk(sys_clk), .nrst(nrst), .bus(lone_if), .rd_req(rd_req_b), .ready(ready_b),
    .done(done_b), .err(err_b), .hum_tenths(), .temp_neg(), .temp_mag());
  owl_link_monitor owl_link_monitor_inst (
    .sys_clk(sys_clk), .nrst(nrst), .line(link_if.line), .dev_out(link_if.dev_out),
    .dev_oe(link_if.dev_oe), .host_out(link_if.host_out), .host_oe(link_if.host_oe));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic pick(input int sel);
    case (sel)
      0: return meas_req;
      1: return ready;
      2: return done;
      3: return ready_b;
      default: return err_b;
    endcase
  endfunction : pick

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic compare(input string what, input logic [39:0] expv, input logic [39:0] got);
    checks++;
    if (expv !== got) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, expv, got);
    end
  endtask : compare

  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_for(input int sel, input logic v, input int lim, input string what);
    for (int i = 0; i < lim && pick(sel) !== v; i++) @(negedge sys_clk);
    compare(what, 40'(v), 40'(pick(sel)));
    if (pick(sel) !== v) end_of_test();
  endtask : wait_for

  // ----------------------------------------
  // measurement source with random stalls
  // ----------------------------------------
  always @(negedge sys_clk) begin
    logic [7:0] chk;
    if (nrst === 1'b1 && meas_req === 1'b1) begin
      if (meas_valid !== 1'b1) begin
        rnd = lfsr(rnd);
        if (rnd[0]) begin
          chk = 8'(rnd[15:8] + rnd[7:0] + {nmeas[0], rnd[30:24]} + rnd[23:16]);
          hum_tenths <= rnd[15:0];
          temp_mag   <= rnd[30:16];
          temp_neg   <= nmeas[0];
          meas_valid <= 1'b1;
          exp_q.push_back({rnd[15:0], nmeas[0], rnd[30:16]});
          wexp_q.push_back({rnd[15:0], nmeas[0], rnd[30:16], chk});
          nmeas++;
        end
      end
    end else begin
      meas_valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // result watchers: host outputs and raw line
  // ----------------------------------------
  always @(negedge sys_clk) begin
    if (nrst === 1'b1 && done === 1'b1) begin
      compare("sensor asleep", 40'h0000000000, 40'(awake));
      if (exp_q.size() > 0) compare("host data", 40'(exp_q.pop_front()),
                                    40'({hum_out, neg_out, mag_out}));
      else compare("host data queue", 40'h0000000001, 40'h0000000000);
    end
    if (nrst === 1'b1 && err !== 1'b0) compare("host err", 40'h0000000000, 40'(err));
  end

  // line decoder: a long low marks the response, each later fall ends a bit
  always @(negedge sys_clk) begin
    if (link_if.line !== line_d) begin
      if (link_if.line === 1'b1) begin
        lowlen = run;
      end else if (lowlen >= 750) begin
        nb = 0;
        compare("sensor awake", 40'h0000000001, 40'(awake));
      end else if (nb < 40) begin
        sh = {sh[38:0], run > 490};
        nb++;
        if (nb == 40 && wexp_q.size() > 0) compare("wire frame", wexp_q.pop_front(), sh);
      end
      run = 0;
      line_d = link_if.line;
    end
    run++;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
    for (int f = 0; f < 2; f++) begin
      wait_for(0, 1'b0, 200, "measurement taken");
      wait_for(1, 1'b1, 200, "host ready");
      rd_req = 1'b1;
      wait_for(1, 1'b0, 4, "read taken");
      rd_req = 1'b0;
      wait_for(2, 1'b1, 52000, "frame done");
      $display("frame %0d finished", f);
    end
    wait_for(3, 1'b1, 200, "lone host ready");
    rd_req_b = 1'b1;
    wait_for(3, 1'b0, 4, "lone read taken");
    rd_req_b = 1'b0;
    wait_for(4, 1'b1, 3000, "silent sensor error");
    compare("silent sensor done", 40'h0000000000, 40'(done_b));
    $display("silent sensor test finished");
    end_of_test();
  end
endmodule : test_one_wire_sensor_readout_link
